/* File: logic/dzqcal_defines.svh */
// timing counts and command encodings for the calibration block
// assumes a 125 MHz ref_clk and a memory clock sampled as a pin
`ifndef DZQCAL_DEFINES_SVH
`define DZQCAL_DEFINES_SVH
// windows in memory clock cycles
`define DZQCAL_INIT_WIN_NCK 16'h0200
`define DZQCAL_OPER_WIN_NCK 16'h0100
`define DZQCAL_SHORT_WIN_NCK 16'h0040
// engine correction span within the short window, memory clocks
`define DZQCAL_CORR_NCK 16'h0040
// engine step counts; the short run stays inside the correction span
`define DZQCAL_LONG_STEPS 8'hc0
`define DZQCAL_SHORT_STEPS 8'h38
// calibration command: cs_n ras_n cas_n we_n
`define DZQCAL_CMD_CODE 4'h6
`endif

/* File: logic/dzqcal_engine.sv */
// linear tracking calibration engine
// assumes a comparator input already synchronised
module dzqcal_engine
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cmp_hi,
   input wire logic [7:0] steps,
   dzqcal_if.eng eng
);
   logic [7:0] ron_r; // driver trial code
   logic [7:0] rtt_r; // termination trial code
   logic [7:0] cnt_r; // steps left
   logic busy_r; // run in progress
   logic done_r; // completion pulse

   // step codes toward comparator balance
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ron_r <= 8'h80;
         rtt_r <= 8'h80;
         cnt_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else if (eng.start)
      begin
         busy_r <= 1'b1;
         cnt_r <= steps;
         done_r <= 1'b0;
      end
      else if (busy_r)
      begin
         // move one code step per cycle
         ron_r <= cmp_hi ? ron_r + 8'h01 : ron_r - 8'h01;
         rtt_r <= cmp_hi ? rtt_r + 8'h01 : rtt_r - 8'h01;
         cnt_r <= cnt_r - 8'h01;
         busy_r <= (cnt_r != 8'h01);
         done_r <= (cnt_r == 8'h01);
      end
      else
      begin
         done_r <= 1'b0;
      end
   end

   assign eng.done = done_r;
   assign eng.ron_code = ron_r;
   assign eng.rtt_code = rtt_r;
endmodule

/* File: logic/dzqcal_if.sv */
// engine hand-shake between controller and calibration engine
// assumes one ref_clk domain
interface dzqcal_if;
   logic start; // pulse, begin a run
   logic full; // long run when high
   logic done; // pulse, codes ready
   logic [7:0] ron_code; // driver code result
   logic [7:0] rtt_code; // termination code result
   modport ctrl (output start, output full, input done, input ron_code, input rtt_code);
   modport eng (input start, input full, output done, output ron_code, output rtt_code);
endinterface

/* File: logic/dzqcal_pkg.sv */
// types shared by the calibration block
// assumes nothing beyond the defines header
package dzqcal_pkg;
   // calibration controller states
   typedef enum logic [1:0] {dzqcal_idle, dzqcal_run, dzqcal_xfer} dzqcal_state_t;
   // impedance code word
   typedef logic [7:0] dzqcal_code_t;
endpackage

/* File: logic/dzqcal_top.sv */
// impedance calibration command handling inside the memory device
// assumes mem_clk and command pins arrive asynchronous to ref_clk
`include "dzqcal_defines.svh"
module dzqcal_top
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic mem_clk,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic addr_a10,
   input wire logic sr_exit,
   input wire logic cmp_hi,
   output logic cal_current_en,
   output logic [7:0] drive_code,
   output logic [7:0] term_code,
   output logic cal_busy,
   output logic dq_oe_n
);
   // three-stage synchronisers: [0] first, [1] second, [2] third
   logic [2:0] clk_s_r;
   logic [2:0] cmd_s_r [5];
   logic [4:0] pins_raw;
   logic [4:0] pins_q; // agreed command/address pin levels
   logic mclk_q_r; // agreed memory clock level
   logic mclk_rise; // memory clock edge found
   logic cmd_hit; // calibration command sampled
   logic first_done_r; // first long calibration seen
   logic [15:0] win_r; // memory clocks left in window
   logic full_r; // current run is long
   logic xfer_r; // codes transferred
   dzqcal_pkg::dzqcal_state_t state_r;
   dzqcal_if eif();

   assign pins_raw = {addr_a10, we_n, cas_n, ras_n, cs_n};

   // memory clock sampled as a pin
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         clk_s_r <= 3'h0;
         mclk_q_r <= 1'b0;
      end
      else
      begin
         clk_s_r <= {clk_s_r[1:0], mem_clk};
         // change accepted once stages two and three agree
         if (clk_s_r[1] == clk_s_r[2])
         begin
            mclk_q_r <= clk_s_r[2];
         end
      end
   end

   // rising edge of the agreed memory clock
   assign mclk_rise = (clk_s_r[1] == clk_s_r[2]) && clk_s_r[2] && !mclk_q_r;

   // command pins synchronised the same way
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_pin
         logic agree_r; // agreed level of this pin
         always_ff @(posedge ref_clk)
         begin
            if (!rst_n)
            begin
               cmd_s_r[gi] <= 3'h7;
               agree_r <= 1'b1;
            end
            else
            begin
               cmd_s_r[gi] <= {cmd_s_r[gi][1:0], pins_raw[gi]};
               // change accepted once stages two and three agree
               if (cmd_s_r[gi][1] == cmd_s_r[gi][2])
               begin
                  agree_r <= cmd_s_r[gi][2];
               end
            end
         end
         assign pins_q[gi] = agree_r;
      end
   endgenerate

   // calibration command decoded at a memory clock edge
   assign cmd_hit = mclk_rise && ({pins_q[0], pins_q[1], pins_q[2], pins_q[3]} == `DZQCAL_CMD_CODE);

   // window length for the decoded command
   function automatic logic [15:0] win_len(input logic long_cmd, input logic first_done);
      if (long_cmd && !first_done)
      begin
         win_len = `DZQCAL_INIT_WIN_NCK;
      end
      else if (long_cmd)
      begin
         win_len = `DZQCAL_OPER_WIN_NCK;
      end
      else
      begin
         win_len = `DZQCAL_SHORT_WIN_NCK;
      end
   endfunction

   // calibration sequencing over the window
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_r <= dzqcal_pkg::dzqcal_idle;
         win_r <= 16'h0000;
         full_r <= 1'b0;
         first_done_r <= 1'b0;
         xfer_r <= 1'b0;
      end
      else
      begin
         xfer_r <= 1'b0;
         case (state_r)
            dzqcal_pkg::dzqcal_idle:
            begin
               // only an explicit command starts a run, never sr_exit
               if (cmd_hit && pins_q[4])
               begin
                  state_r <= dzqcal_pkg::dzqcal_run;
                  full_r <= 1'b1;
                  win_r <= win_len(1'b1, first_done_r);
                  first_done_r <= 1'b1;
               end
               else if (cmd_hit)
               begin
                  state_r <= dzqcal_pkg::dzqcal_run;
                  full_r <= 1'b0;
                  win_r <= win_len(1'b0, first_done_r);
               end
            end
            dzqcal_pkg::dzqcal_run:
            begin
               if (eif.done)
               begin
                  state_r <= dzqcal_pkg::dzqcal_xfer;
                  xfer_r <= 1'b1;
               end
               if (mclk_rise && win_r != 16'h0000)
               begin
                  win_r <= win_r - 16'h0001;
               end
            end
            dzqcal_pkg::dzqcal_xfer:
            begin
               // codes moved once on entry, then wait out the quiet window
               if (mclk_rise && win_r != 16'h0000)
               begin
                  win_r <= win_r - 16'h0001;
               end
               else if (win_r == 16'h0000)
               begin
                  state_r <= dzqcal_pkg::dzqcal_idle;
               end
            end
            default:
            begin
               state_r <= dzqcal_pkg::dzqcal_idle;
            end
         endcase
      end
   end

   // engine start, one pulse on entering run
   logic start_r;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         start_r <= 1'b0;
      end
      else
      begin
         start_r <= (state_r == dzqcal_pkg::dzqcal_idle) && cmd_hit;
      end
   end
   assign eif.start = start_r;
   assign eif.full = full_r;

   // engine steps: short run bounded by the correction span
   logic [7:0] steps;
   assign steps = full_r ? `DZQCAL_LONG_STEPS : `DZQCAL_SHORT_STEPS;

   dzqcal_engine u_eng
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .cmp_hi(cmp_hi),
      .steps(steps),
      .eng(eif)
   );

   // calibrated codes reach the I/O on transfer
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         drive_code <= 8'h80;
         term_code <= 8'h80;
      end
      else if (xfer_r)
      begin
         drive_code <= eif.ron_code;
         term_code <= eif.rtt_code;
      end
   end

   // current path only while the engine works; data pins stay released
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cal_current_en <= 1'b0;
         cal_busy <= 1'b0;
         dq_oe_n <= 1'b1;
      end
      else
      begin
         cal_current_en <= (state_r == dzqcal_pkg::dzqcal_run) && !eif.done;
         cal_busy <= (state_r != dzqcal_pkg::dzqcal_idle);
         dq_oe_n <= 1'b1;
      end
   end
endmodule

/* File: testbench/dzqcal_ctrl_model.sv */
// controller model: free memory clock and commands
// assumes ten ref_clk cycles per half memory clock
`include "dzqcal_defines.svh"
module dzqcal_ctrl_model
(
   input wire logic ref_clk,
   input wire logic req,
   input wire logic long_sel,
   output logic mem_clk,
   output logic [3:0] cmd,
   output logic cke,
   output logic addr_a10
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_r; // half period count
   logic pend_r; // command waiting
   logic on_r; // command on the pins
   initial
   begin
      {cnt_r, pend_r, on_r, mem_clk} = '0;
      cmd = 4'hf;
      addr_a10 = 1'b0;
      cke = 1'b1;
      // no termination input is driven, so termination stays off
   end
   // pins change after a falling edge, held one full period
   always @(posedge ref_clk)
   begin
      pend_r <= pend_r | req;
      cnt_r <= (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == 4'h9)
      begin
         mem_clk <= !mem_clk;
         if (mem_clk && on_r)
         begin
            cmd <= 4'hf;
            addr_a10 <= !addr_a10; // released address flips
            on_r <= 1'b0;
         end
         else if (mem_clk && pend_r)
         begin
            cmd <= `DZQCAL_CMD_CODE;
            addr_a10 <= long_sel;
            on_r <= 1'b1;
            pend_r <= req;
         end
      end
   end
endmodule

/* File: testbench/dzqcal_properties.sv */
// port checker for the calibration windows
// assumes mem_clk is much slower than ref_clk
`include "dzqcal_defines.svh"
module dzqcal_properties
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic mem_clk,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic addr_a10,
   input wire logic sr_exit,
   input wire logic cmp_hi,
   input wire logic cal_current_en,
   input wire logic [7:0] drive_code,
   input wire logic [7:0] term_code,
   input wire logic cal_busy,
   input wire logic dq_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [9:0] n_r; // memory clocks inside window
   logic [9:0] lim_r; // window due for this command
   logic used_r; // a long run was seen
   wire logic cmd = ({cs_n, ras_n, cas_n, we_n} == `DZQCAL_CMD_CODE);
   // count memory clocks while busy
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || $rose(cal_busy))
         n_r <= 10'h000;
      else if (cal_busy && $rose(mem_clk))
         n_r <= n_r + 10'h001;
   end
   // window length from command kind
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         used_r <= 1'b0;
      else if ($rose(cal_busy))
      begin
         used_r <= used_r | addr_a10;
         lim_r <= !addr_a10 ? 10'h040 : (used_r ? 10'h100 : 10'h200);
      end
   end
   a_data_released: assert property (dq_oe_n)
      else $error("data driver enabled");
   a_current_in_busy: assert property (cal_current_en |-> cal_busy)
      else $error("current outside window");
   a_current_cause: assert property ($rose(cal_current_en) |-> $rose(cal_busy))
      else $error("engine ran without command");
   a_codes_idle: assert property (!cal_busy && !$past(cal_busy) |-> $stable(drive_code) && $stable(term_code))
      else $error("codes moved while idle");
   a_window_len: assert property ($fell(cal_busy) |-> n_r + 10'h002 >= lim_r && n_r <= lim_r + 10'h002)
      else $error("window length wrong");
   a_cmd_start: assert property ($rose(mem_clk) && cmd && !cal_busy |-> ##[2:10] cal_busy)
      else $error("command not taken");
   a_engine_done: assert property ($fell(cal_busy) |-> !$past(cal_current_en))
      else $error("engine still running");
   c_long: cover property ($rose(cal_busy) && addr_a10);
   c_short: cover property ($rose(cal_busy) && !addr_a10);
   c_sr: cover property (sr_exit && !cal_busy);
endmodule
bind dzqcal_top dzqcal_properties chk_u (.*);

/* File: testbench/tb_top.sv */
// top testbench for the calibration block
// assumes the controller model drives the command pins
`include "dzqcal_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_n = 0, req = 0, lsel = 0, sr_exit = 0, cmp_hi = 0;
   logic mem_clk, cke, a10, cur, busy, oe_n;
   logic [3:0] cmd;
   logic [7:0] dcode, tcode;
   int fail_count = 0, n_tests = 0;
   always #4 ref_clk = !ref_clk;
   dzqcal_ctrl_model ctl_u (.ref_clk(ref_clk), .req(req), .long_sel(lsel), .mem_clk(mem_clk), .cmd(cmd),
      .cke(cke), .addr_a10(a10));
   dzqcal_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .mem_clk(mem_clk), .cs_n(cmd[3]), .ras_n(cmd[2]),
      .cas_n(cmd[1]), .we_n(cmd[0]), .cke(cke), .addr_a10(a10), .sr_exit(sr_exit), .cmp_hi(cmp_hi),
      .cal_current_en(cur), .drive_code(dcode), .term_code(tcode), .cal_busy(busy), .dq_oe_n(oe_n));
   task chk(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // self-refresh exit alone must not start a run
   task t_sr;
      sr_exit <= 1;
      repeat (60) @(posedge ref_clk);
      sr_exit <= 0;
      chk("sr busy", 16'h0000, 16'({busy, cur}));
      chk("sr codes", 16'h8080, {dcode, tcode});
      $display("self refresh test done");
   endtask
   // one command, measure its window; mid adds an ignored command
   task t_win(string nm, logic l, logic [15:0] lim, logic mid, logic hi);
      int n, k, seen;
      logic pm;
      logic [7:0] cb;
      logic [7:0] ce;
      n = 0;
      k = 0;
      seen = 0;
      // codes move one step per engine cycle toward the comparator
      cb = dcode;
      ce = l ? `DZQCAL_LONG_STEPS : `DZQCAL_SHORT_STEPS;
      ce = hi ? cb + ce : cb - ce;
      cmp_hi <= hi;
      lsel <= l;
      req <= 1;
      @(posedge ref_clk) req <= 0;
      while (busy !== 1'b1 && k < 80)
         @(posedge ref_clk) k++;
      chk("busy rise", 16'h0001, 16'(busy));
      pm = mem_clk;
      k = 0;
      while (busy === 1'b1 && k < 12000)
      begin
         @(posedge ref_clk);
         k++;
         n += (mem_clk && !pm);
         pm = mem_clk;
         seen |= cur;
         req <= (mid && k == 300);
      end
      chk("window ok", 16'h0001, 16'(n + 2 >= lim && n <= lim + 2));
      chk("current seen", 16'h0001, 16'(seen));
      chk("current off", 16'h0000, 16'(cur));
      chk("dq released", 16'h0001, 16'(oe_n));
      chk("codes", {ce, ce}, {dcode, tcode});
      $display("%s test done, %0d clocks", nm, n);
      repeat (4) @(posedge ref_clk);
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1;
      repeat (4) @(posedge ref_clk);
      chk("reset codes", 16'h8080, {dcode, tcode});
      chk("reset pins", 16'h0001, 16'({busy, cur, oe_n}));
      t_sr;
      t_win("first long", 1, 16'h0200, 0, 1);
      t_win("later long", 1, 16'h0100, 1, 0);
      t_win("short", 0, 16'h0040, 0, 1);
      stop_test;
   end
   // hang guard
   initial
   begin
      #240000;
      fail_count++;
      stop_test;
   end
endmodule
